// ### qrst_map.svh
// qrst_map.svh: timing counts and counter limits for the quasi-resonant switch timing block
// assumes a 100 MHz system clock; times are given in ns and converted to cycles here
`ifndef QRST_MAP_SVH
`define QRST_MAP_SVH
`define QRST_CLK_PERIOD_NS     10
`define QRST_VALLEY_MAX        3'h7
`define QRST_UDC_MAX           3'h7
`define QRST_UDC_MIN           3'h1
`define QRST_RING_LONG_NS      5000
`define QRST_RING_SHORT_NS     2500
`define QRST_RING_LONG_CYC     ((`QRST_RING_LONG_NS + `QRST_CLK_PERIOD_NS - 1) / `QRST_CLK_PERIOD_NS)
`define QRST_RING_SHORT_CYC    ((`QRST_RING_SHORT_NS + `QRST_CLK_PERIOD_NS - 1) / `QRST_CLK_PERIOD_NS)
`define QRST_LEB_NS            220
`define QRST_LEB_CYC           ((`QRST_LEB_NS + `QRST_CLK_PERIOD_NS - 1) / `QRST_CLK_PERIOD_NS)
`define QRST_SW_BLANK_NS       190
`define QRST_SW_BLANK_CYC      ((`QRST_SW_BLANK_NS + `QRST_CLK_PERIOD_NS - 1) / `QRST_CLK_PERIOD_NS)
`define QRST_OVP_BLANK_NS      1000
`define QRST_OVP_BLANK_CYC     ((`QRST_OVP_BLANK_NS + `QRST_CLK_PERIOD_NS - 1) / `QRST_CLK_PERIOD_NS)
`define QRST_MAX_ON_NS         30000
`define QRST_MAX_ON_CYC        (`QRST_MAX_ON_NS / `QRST_CLK_PERIOD_NS)
`define QRST_MAX_OFF_NS        50000
`define QRST_MAX_OFF_CYC       (`QRST_MAX_OFF_NS / `QRST_CLK_PERIOD_NS)
`define QRST_UDC_PERIOD_NS     48000000
`define QRST_UDC_PERIOD_CYC    (`QRST_UDC_PERIOD_NS / `QRST_CLK_PERIOD_NS)
`define QRST_BURST_BLANK_NS    20000000
`define QRST_BURST_BLANK_CYC   (`QRST_BURST_BLANK_NS / `QRST_CLK_PERIOD_NS)
`endif

// ### qrst_pkg.sv
// qrst_pkg.sv: types of the quasi-resonant switch timing block
// assumes qrst_map.svh supplies the numeric constants
`default_nettype none
package qrst_pkg;
   // comparator results from the power stage; qrst_core synchronises them
   typedef struct packed {
      logic valley;       // aux sense above 100mV level
      logic ovp;          // aux sense above output overvoltage level
      logic ring_sel;     // aux sense above ringing select level
      logic cs_trip;      // scaled current above feedback voltage
      logic cs_limit;     // sense above mains-adjusted (folded back) limit
      logic short_wind;   // sense above short winding level
      logic fold_exceed;  // aux pin current above foldback threshold
      logic fb_zl;        // feedback above low counting level
      logic fb_zh;        // feedback above high counting level
      logic fb_r1;        // feedback above reset level
      logic fb_burst;     // feedback below burst entry level
   } qrst_cmp_s;
   typedef enum logic [1:0] {QRST_OFF_RING, QRST_OFF_WAIT, QRST_ON, QRST_LATCHED} qrst_state_e;
   typedef logic [2:0] qrst_count_t;
endpackage : qrst_pkg
`default_nettype wire

// ### qrst_core.sv
// qrst_core.sv: gate timing, valley counting, protections, load counter and burst entry
// assumes comparator inputs come asynchronously from the analog front end
`timescale 1ns/1ns
`default_nettype none
`include "qrst_map.svh"
// What this block does
// - valley counter saturates within zero to seven
// - while off, each falling crossing of the 100mV level adds one
// - valley counter clears whenever the gate turns on
// - overvoltage while off latches off after a fixed blanking interval
// - ringing suppression long below select level, short above it
// - gate stays off until ringing suppression expires
// - after suppression, turn on when valley count reaches load counter
// - turn on after maximum off interval regardless of counters
// - switch off when scaled current exceeds feedback voltage
// - switch-off comparators ignored during leading edge blanking
// - force off after maximum on interval
// - current limit trip turns gate off on the clock edge after it is seen
// - short winding comparator qualified by spike blanking, then latch off
// - foldback excess current lowers sense limit via offset request
// - burst latch set when feedback low and counter at 7 for blanking time
// - load counter updated every 48ms from three feedback levels
// - load counter starts at one
module qrst_core (
   input  wire logic             clk_sys_in,
   input  wire logic             resetn_in,
   input  wire qrst_pkg::qrst_cmp_s cmp_in,
   output logic                  gate_drive_output_out,
   output logic                  latch_off_out,
   output logic                  burst_entry_out,
   output logic                  foldback_active_out,
   output logic [2:0]            valley_counter_out,
   output logic [2:0]            load_count_out
);
   localparam int unsigned MAX_OFF  = `QRST_MAX_OFF_CYC;
   localparam int unsigned PERIOD   = `QRST_UDC_PERIOD_CYC;
   localparam int unsigned BBLANK   = `QRST_BURST_BLANK_CYC;

   qrst_pkg::qrst_cmp_s s1_r, s2_r, s1_nxt, s2_nxt;
   always_comb begin
      s1_nxt = cmp_in;
      s2_nxt = s1_r;
   end
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   qrst_pkg::qrst_state_e st_r, st_nxt;
   logic [31:0] tim_r, tim_nxt, ring_r, ring_nxt, ovp_r, ovp_nxt, sw_r, sw_nxt;
   logic [31:0] per_r, per_nxt, bb_r, bb_nxt;
   logic        valley_d_r, valley_d_nxt, zl_r, zl_nxt, zh_r, zh_nxt, r1_r, r1_nxt;
   logic        burst_r, burst_nxt, fold_r, fold_nxt;
   qrst_pkg::qrst_count_t vc_r, vc_nxt, udc_r, udc_nxt;
   logic        gate_r, gate_nxt, off_now, on_now;
   logic        latch_r, latch_nxt;

   always_comb begin
      st_nxt = st_r;
      tim_nxt = tim_r + 32'h1;
      ring_nxt = (ring_r != 32'h0) ? ring_r - 32'h1 : 32'h0;
      ovp_nxt = 32'h0;
      sw_nxt = 32'h0;
      vc_nxt = vc_r;
      valley_d_nxt = s2_r.valley;
      gate_nxt = gate_r;
      fold_nxt = 1'b0;
      off_now = 1'b0;
      on_now = 1'b0;
      unique case (st_r)
         qrst_pkg::QRST_OFF_RING, qrst_pkg::QRST_OFF_WAIT: begin
            if (valley_d_r && !s2_r.valley && vc_r != `QRST_VALLEY_MAX)
               vc_nxt = vc_r + 3'h1;
            if (s2_r.ovp)
               ovp_nxt = ovp_r + 32'h1;
            if (ovp_r >= 32'(`QRST_OVP_BLANK_CYC) - 32'h1 && s2_r.ovp)
               st_nxt = qrst_pkg::QRST_LATCHED;
            else if (st_r == qrst_pkg::QRST_OFF_RING) begin
               if (ring_r <= 32'h1)
                  st_nxt = qrst_pkg::QRST_OFF_WAIT;
            end else if (vc_r >= udc_r && !burst_r)
               on_now = 1'b1;
            if (st_nxt != qrst_pkg::QRST_LATCHED && !burst_r
                && tim_r >= 32'(MAX_OFF) - 32'h1)
               on_now = 1'b1;
            if (on_now) begin
               st_nxt = qrst_pkg::QRST_ON;
               gate_nxt = 1'b1;
               vc_nxt = 3'h0;
               tim_nxt = 32'h0;
            end
         end
         qrst_pkg::QRST_ON: begin
            fold_nxt = s2_r.fold_exceed;
            if (tim_r >= 32'(`QRST_LEB_CYC)) begin
               if (s2_r.cs_trip || s2_r.cs_limit) off_now = 1'b1;
               if (s2_r.short_wind) sw_nxt = sw_r + 32'h1;
            end
            if (tim_r >= 32'(`QRST_MAX_ON_CYC) - 32'h1) off_now = 1'b1;
            if (sw_r >= 32'(`QRST_SW_BLANK_CYC) - 32'h1 && s2_r.short_wind) begin
               st_nxt = qrst_pkg::QRST_LATCHED;
               gate_nxt = 1'b0;
            end else if (off_now) begin
               st_nxt = qrst_pkg::QRST_OFF_RING;
               gate_nxt = 1'b0;
               tim_nxt = 32'h0;
               ring_nxt = s2_r.ring_sel ? 32'(`QRST_RING_SHORT_CYC)
                                        : 32'(`QRST_RING_LONG_CYC);
            end
         end
         qrst_pkg::QRST_LATCHED: begin
            gate_nxt = 1'b0;
            tim_nxt = tim_r;
         end
      endcase
      // latch flag registered alongside the state so the output comes from a flop
      latch_nxt = (st_nxt == qrst_pkg::QRST_LATCHED);
   end

   always_comb begin
      per_nxt = per_r + 32'h1;
      zl_nxt = zl_r | s2_r.fb_zl;
      zh_nxt = zh_r | s2_r.fb_zh;
      r1_nxt = r1_r | s2_r.fb_r1;
      udc_nxt = udc_r;
      if (per_r >= 32'(PERIOD) - 32'h1) begin
         per_nxt = 32'h0;
         zl_nxt = 1'b0;
         zh_nxt = 1'b0;
         r1_nxt = 1'b0;
         // decide on the levels seen over the whole window, this cycle included
         if (r1_r | s2_r.fb_r1) udc_nxt = `QRST_UDC_MIN;
         else if (zh_r | s2_r.fb_zh) udc_nxt = (udc_r > `QRST_UDC_MIN) ? udc_r - 3'h1 : udc_r;
         else if (!(zl_r | s2_r.fb_zl)) udc_nxt = (udc_r < `QRST_UDC_MAX) ? udc_r + 3'h1 : udc_r;
      end
      bb_nxt = (s2_r.fb_burst && udc_r == `QRST_UDC_MAX) ? bb_r + 32'h1 : 32'h0;
      burst_nxt = burst_r | (bb_r >= 32'(BBLANK) - 32'h1 && s2_r.fb_burst
                             && udc_r == `QRST_UDC_MAX);
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r <= qrst_pkg::QRST_OFF_RING;
         latch_r <= 1'b0;
         tim_r <= 32'h0;
         ring_r <= 32'(`QRST_RING_LONG_CYC);
         ovp_r <= 32'h0;
         sw_r <= 32'h0;
         vc_r <= 3'h0;
         valley_d_r <= 1'b0;
         gate_r <= 1'b0;
         fold_r <= 1'b0;
         per_r <= 32'h0;
         zl_r <= 1'b0;
         zh_r <= 1'b0;
         r1_r <= 1'b0;
         udc_r <= `QRST_UDC_MIN;
         bb_r <= 32'h0;
         burst_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         latch_r <= latch_nxt;
         tim_r <= tim_nxt;
         ring_r <= ring_nxt;
         ovp_r <= ovp_nxt;
         sw_r <= sw_nxt;
         vc_r <= vc_nxt;
         valley_d_r <= valley_d_nxt;
         gate_r <= gate_nxt;
         fold_r <= fold_nxt;
         per_r <= per_nxt;
         zl_r <= zl_nxt;
         zh_r <= zh_nxt;
         r1_r <= r1_nxt;
         udc_r <= udc_nxt;
         bb_r <= bb_nxt;
         burst_r <= burst_nxt;
      end
   end

   assign gate_drive_output_out = gate_r;
   assign latch_off_out         = latch_r;
   assign burst_entry_out       = burst_r;
   assign foldback_active_out   = fold_r;
   assign valley_counter_out    = vc_r;
   assign load_count_out        = udc_r;

   // a drop of the valley count is only legal as the clear at turn-on; a wrap shows here
   a_valley_range: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      vc_r < $past(vc_r) |-> vc_r == 3'h0 && $rose(gate_r))
      else $error("valley count wrapped or dropped");
   a_valley_clear: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(gate_r) |-> vc_r == 3'h0) else $error("valley count not cleared");
   a_ring_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $fell(gate_r) |-> !gate_r [*8]) else $error("gate back on during ringing");
   a_leb_min_on: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(gate_r) |-> gate_r [*8]) else $error("gate shorter than blanking");
   a_max_on: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      gate_r |-> tim_r < 32'(`QRST_MAX_ON_CYC)) else $error("gate on too long");
   a_trip_off: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (st_r == qrst_pkg::QRST_ON && tim_r >= 32'(`QRST_LEB_CYC) && s2_r.cs_trip)
      |=> !gate_r)
      else $error("current trip ignored");
   a_udc_range: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      udc_r >= 3'h1 && udc_r <= 3'h7) else $error("load counter out of range");
   a_burst_cause: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(burst_r) |-> $past(udc_r) == 3'h7 && $past(s2_r.fb_burst))
      else $error("burst set without cause");
   a_latch_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      latch_off_out |=> latch_off_out && !gate_r) else $error("latch released");
   a_leb_on_time: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $fell(gate_r) |-> $past(tim_r) >= 32'(`QRST_LEB_CYC))
      else $error("gate off inside blanking");
   a_turn_on_cause: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(gate_r) |-> $past(st_r) == qrst_pkg::QRST_OFF_WAIT
                        || $past(tim_r) >= 32'(MAX_OFF) - 32'h1)
      else $error("gate on during ringing suppression");
   a_valley_turn_on: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(gate_r) && $past(tim_r) < 32'(MAX_OFF) - 32'h1 |-> $past(vc_r) >= $past(udc_r))
      else $error("gate on before enough valleys");
   a_udc_step: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      udc_r != $past(udc_r) |-> $past(per_r) == 32'(PERIOD) - 32'h1)
      else $error("load counter moved inside its window");
   a_ovp_blank: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(latch_r) && !$past(gate_r) |-> $past(ovp_r) >= 32'(`QRST_OVP_BLANK_CYC) - 32'h1)
      else $error("overvoltage latch before blanking");
   a_sw_blank: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(latch_r) && $past(gate_r) |-> $past(sw_r) >= 32'(`QRST_SW_BLANK_CYC) - 32'h1)
      else $error("short winding latch before blanking");
endmodule : qrst_core
`default_nettype wire

// ### qrst_stage.sv
// qrst_stage.sv: flyback power stage model giving the comparator levels
// assumes bench controls stay steady within the gate phase that uses them
`timescale 1ns/1ns
`default_nettype none
module qrst_stage (
   input  wire logic            clk_sys_in,
   input  wire logic            resetn_in,
   input  wire logic            gate_in,
   input  wire logic            ring_hi_in,
   input  wire logic            ovp_in,
   input  wire logic            fold_in,
   input  wire logic [1:0]      sel_in,
   input  wire logic [3:0]      nval_in,
   input  wire logic [11:0]     dly_in,
   output qrst_pkg::qrst_cmp_s  cmp_out
);
   logic [12:0] on_r;
   logic [12:0] off_r;
   logic        trip;
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         on_r  <= 13'h0;
         off_r <= 13'h0;
      end else begin
         on_r  <= gate_in ? on_r + 13'h1 : 13'h0;
         off_r <= gate_in ? 13'h0 : off_r + 13'h1;
      end
   end
   always_comb begin
      trip = gate_in && dly_in != 12'h0 && on_r >= {1'b0, dly_in};
      cmp_out = '0;
      cmp_out.cs_trip = trip && sel_in == 2'h0;
      cmp_out.cs_limit = trip && sel_in == 2'h1;
      cmp_out.short_wind = trip && sel_in == 2'h2;
      cmp_out.fold_exceed = gate_in && fold_in;
      // one ringing valley per 16 off cycles, falling at 16, 32, ...
      cmp_out.valley = !gate_in && off_r[3] && off_r[12:4] < {5'h0, nval_in};
      cmp_out.ring_sel = ring_hi_in;
      cmp_out.ovp = !gate_in && ovp_in;
      cmp_out.fb_zl = 1'b1;
   end
endmodule : qrst_stage
`default_nettype wire

// ### tb_quasi_resonant_switch_timing.sv
// tb_quasi_resonant_switch_timing.sv: self-checking bench of the switch timing core
// assumes qrst_stage as power stage, 100 MHz clock, inputs driven at falling edge
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_quasi_resonant_switch_timing;
   logic                clk_sys_in = 1'b0;
   logic                resetn_in = 1'b0;
   logic                ring_hi = 1'b0;
   logic                ovp = 1'b0;
   logic                fold = 1'b0;
   logic [1:0]          sel = 2'h0;
   logic [3:0]          nval = 4'h3;
   logic [11:0]         dly = 12'h3;
   qrst_pkg::qrst_cmp_s cmp;
   logic                gate, latch, burst, fbk;
   logic [2:0]          vcnt, load;
   int                  errors = 0, checks_done = 0, cyc = 0, n, k;
   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 80000) begin
         errors++;
         end_of_test();
      end
   end
   qrst_stage model (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .gate_in(gate),
      .ring_hi_in(ring_hi), .ovp_in(ovp), .fold_in(fold), .sel_in(sel), .nval_in(nval),
      .dly_in(dly), .cmp_out(cmp));
   qrst_core dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cmp_in(cmp),
      .gate_drive_output_out(gate), .latch_off_out(latch), .burst_entry_out(burst),
      .foldback_active_out(fbk), .valley_counter_out(vcnt), .load_count_out(load));
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   task automatic wait_gate(input logic v, output int c);
      c = 0;
      while (gate !== v && c < 6000) begin
         @(negedge clk_sys_in);
         c++;
      end
      if (c == 6000) errors++;
   endtask : wait_gate
   function automatic int off_lo(logic r, logic [3:0] v);
      return (v == 4'h0) ? 4999 : (r ? 249 : 499);
   endfunction : off_lo
   function automatic int on_lo(logic [11:0] d);
      return (d == 12'h0) ? 2998 : ((d < 12'h14) ? 21 : int'(d));
   endfunction : on_lo
   function automatic logic [2:0] vexp(logic [3:0] v);
      return (v > 4'h7) ? 3'h7 : v[2:0];
   endfunction : vexp
   // one period: on phase set by d, s, f; off phase set by r, v
   task automatic period(input logic r, input logic [3:0] v, input logic [11:0] d,
                         input logic [1:0] s, input logic f);
      int c;
      ring_hi = r;
      nval = v;
      dly = d;
      sel = s;
      fold = f;
      repeat (8) @(negedge clk_sys_in);
      `CHK(fbk, f)
      wait_gate(1'b0, c);
      `CHK(c + 8 >= on_lo(d) && c + 8 <= on_lo(d) + 7, 1'b1)
      repeat (200) @(negedge clk_sys_in);
      `CHK(vcnt, vexp(v))
      wait_gate(1'b1, c);
      `CHK(c + 200 >= off_lo(r, v) && c + 200 <= off_lo(r, v) + 8, 1'b1)
      @(negedge clk_sys_in);
      `CHK(vcnt, 3'h0)
   endtask : period
   initial begin
      void'($urandom(32'hc7da));
      repeat (12) @(negedge clk_sys_in);
      resetn_in = 1'b1;
      @(negedge clk_sys_in);
      `CHK({gate, latch, burst, vcnt, load}, {3'h0, 3'h0, 3'h1})
      wait_gate(1'b1, n);
      `CHK(n >= 498 && n <= 507, 1'b1)
      period(1'b1, 4'ha, 12'h3, 2'h0, 1'b0);
      period(1'b0, 4'h0, 12'h0, 2'h1, 1'b1);
      $display("corner periods done");
      for (k = 0; k < 8; k++) begin
         period(1'($urandom), 4'($urandom % 11), 12'(30 + $urandom % 150),
                2'($urandom % 2), 1'($urandom));
         $display("random period %0d done", k);
      end
      sel = 2'h2;
      dly = 12'h28;
      wait_gate(1'b0, n);
      `CHK(n >= 57 && n <= 66, 1'b1)
      repeat (2) @(negedge clk_sys_in);
      `CHK(latch, 1'b1)
      repeat (5100) @(negedge clk_sys_in);
      `CHK(gate, 1'b0)
      $display("short winding done");
      resetn_in = 1'b0;
      sel = 2'h0;
      dly = 12'h3;
      repeat (2) @(negedge clk_sys_in);
      resetn_in = 1'b1;
      wait_gate(1'b1, n);
      ovp = 1'b1;
      wait_gate(1'b0, n);
      repeat (50) @(negedge clk_sys_in);
      `CHK(latch, 1'b0)
      repeat (100) @(negedge clk_sys_in);
      `CHK(latch, 1'b1)
      repeat (5100) @(negedge clk_sys_in);
      `CHK(gate, 1'b0)
      $display("overvoltage done");
      end_of_test();
   end
endmodule : tb_quasi_resonant_switch_timing
`default_nettype wire
